// ==== logic/port_gate_pkg.sv ====
// Shared constants and types for the sleep port clock gating block
package port_gate_pkg;
  localparam int          NUM_PORTS         = 8;
  localparam logic [11:0] OFF_RUN_GATE      = 12'h108;
  localparam logic [11:0] OFF_SLEEP_GATE    = 12'h118;
  localparam logic [11:0] OFF_DEEP_GATE     = 12'h128;
  localparam logic [11:0] OFF_RUN_CONFIG    = 12'h060;
  localparam logic [11:0] OFF_IRQ_STATUS    = 12'h200;
  localparam logic [11:0] OFF_IRQ_MASK      = 12'h204;
  localparam int          ACG_BIT           = 27;
  localparam logic [31:0] GATE_RESET        = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET      = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET        = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;
  localparam logic [1:0]  RESP_DECERR       = 2'h3;
  localparam int          EVT_FAULT         = 0;
  localparam int          EVT_MODE          = 1;
  localparam int          NUM_EVT           = 2;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'h0,
    MODE_SLEEP = 2'h1,
    MODE_DEEP  = 2'h2
  } power_mode_t;

  // Port-side access request and answer
  typedef struct packed {
    logic       valid;
    logic [2:0] port;
  } port_req_t;

  typedef struct packed {
    logic       fault;
    logic       ok;
  } port_resp_t;
endpackage : port_gate_pkg

// ==== logic/gate_select.sv ====
// Picks the active gating mask for the present power mode
`timescale 1ns/100ps
module gate_select import port_gate_pkg::*; #(
  parameter int N = NUM_PORTS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire power_mode_t mode,
  input  wire logic        auto_gate,
  input  wire logic [N-1:0] run_gate,
  input  wire logic [N-1:0] sleep_gate,
  input  wire logic [N-1:0] deep_gate,
  output logic      [N-1:0] clock_en
);
  logic [N-1:0] en_d;
  logic [N-1:0] en_q;

  always_comb begin
    en_d = run_gate;
    if (auto_gate) begin
      unique case (mode)
        MODE_SLEEP: en_d = sleep_gate;
        MODE_DEEP:  en_d = deep_gate;
        default:    en_d = run_gate;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) en_q <= '0;
    else en_q <= en_d;
  end

  assign clock_en = en_q;
endmodule : gate_select

// ==== logic/port_access_check.sv ====
// Answers port accesses, faulting those aimed at an unclocked port
`timescale 1ns/100ps
module port_access_check import port_gate_pkg::*; #(
  parameter int N = NUM_PORTS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire port_req_t   req,
  input  wire logic [N-1:0] clock_en,
  output port_resp_t       resp
);
  port_resp_t resp_d;
  port_resp_t resp_q;

  always_comb begin
    resp_d = '0;
    if (req.valid) begin
      resp_d.fault = !clock_en[req.port];
      resp_d.ok    = clock_en[req.port];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) resp_q <= '0;
    else resp_q <= resp_d;
  end

  assign resp = resp_q;
endmodule : port_access_check

// ==== logic/sleep_port_clock_gating.sv ====
// Sleep port clock gating: AXI4-Lite registers, mode select and fault flags
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/100ps
module sleep_port_clock_gating import port_gate_pkg::*; #(
  parameter int N = NUM_PORTS
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire power_mode_t mode,
  input  wire port_req_t   port_req,
  output port_resp_t       port_resp,
  output logic [N-1:0]     port_clock_en,
  output logic             irq,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  function automatic logic mapped(input logic [11:0] a);
    return a == OFF_RUN_GATE   ||
           a == OFF_SLEEP_GATE ||
           a == OFF_DEEP_GATE  ||
           a == OFF_RUN_CONFIG ||
           a == OFF_IRQ_STATUS ||
           a == OFF_IRQ_MASK;
  endfunction : mapped

  function automatic logic [N-1:0] merge(input logic [N-1:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [N-1:0] r;
    // Only the low N bits exist, so reserved bits always read zero
    r = old;
    for (int i = 0; i < N; i++) begin
      if (st[i / 8]) r[i] = wd[i];
    end
    return r;
  endfunction : merge

  // Register bank
  logic [N-1:0]       run_gate_q;
  logic [N-1:0]       run_gate_d;
  logic [N-1:0]       sleep_gate_q;
  logic [N-1:0]       sleep_gate_d;
  logic [N-1:0]       deep_gate_q;
  logic [N-1:0]       deep_gate_d;
  logic               acg_q;
  logic               acg_d;
  logic [NUM_EVT-1:0] status_q;
  logic [NUM_EVT-1:0] status_d;
  logic [NUM_EVT-1:0] mask_q;
  logic [NUM_EVT-1:0] mask_d;
  logic               irq_q;
  logic               irq_d;
  // Last sampled mode, for the mode-change flag
  power_mode_t        mode_q;

  // Bus slave state
  logic        aw_held_q;
  logic        aw_held_d;
  logic        w_held_q;
  logic        w_held_d;
  logic [11:0] awaddr_q;
  logic [11:0] awaddr_d;
  logic [31:0] wdata_q;
  logic [31:0] wdata_d;
  logic [3:0]  wstrb_q;
  logic [3:0]  wstrb_d;
  logic        bvalid_q;
  logic        bvalid_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        awready_q;
  logic        awready_d;
  logic        wready_q;
  logic        wready_d;
  logic        arready_q;
  logic        arready_d;

  logic        do_write;
  logic        do_read;
  logic [N-1:0] clock_en;

  // Write commits once address and data are both held
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign do_read  = s_axi_arvalid && arready_q;

  // Bus handshake: one write and one read in flight at most
  always_comb begin
    aw_held_d = aw_held_q;
    w_held_d  = w_held_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;

    if (s_axi_awvalid && awready_q) begin
      aw_held_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_held_d = 1'b1;
      wdata_d  = s_axi_wdata;
      wstrb_d  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end

    if (do_read) begin
      rvalid_d = 1'b1;
      rresp_d  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      rdata_d  = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFF_RUN_GATE:   rdata_d[N-1:0] = run_gate_q;
        OFF_SLEEP_GATE: rdata_d[N-1:0] = sleep_gate_q;
        OFF_DEEP_GATE:  rdata_d[N-1:0] = deep_gate_q;
        OFF_RUN_CONFIG: rdata_d[ACG_BIT] = acg_q;
        OFF_IRQ_STATUS: rdata_d[NUM_EVT-1:0] = status_q;
        OFF_IRQ_MASK:   rdata_d[NUM_EVT-1:0] = mask_q;
        default: ;
      endcase
    end

    // Ready drops as soon as a transfer is held, so none is lost
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
    arready_d = !rvalid_d;
  end

  // Register bank and sticky event flags
  always_comb begin
    run_gate_d   = run_gate_q;
    sleep_gate_d = sleep_gate_q;
    deep_gate_d  = deep_gate_q;
    acg_d        = acg_q;
    mask_d       = mask_q;
    status_d     = status_q;

    if (do_write) begin
      unique case (awaddr_q)
        OFF_RUN_GATE:   run_gate_d   = merge(run_gate_q, wdata_q, wstrb_q);
        OFF_SLEEP_GATE: sleep_gate_d = merge(sleep_gate_q, wdata_q, wstrb_q);
        OFF_DEEP_GATE:  deep_gate_d  = merge(deep_gate_q, wdata_q, wstrb_q);
        OFF_RUN_CONFIG: begin
          if (wstrb_q[ACG_BIT / 8]) begin
            acg_d = wdata_q[ACG_BIT];
          end
        end
        OFF_IRQ_MASK: begin
          if (wstrb_q[0]) begin
            mask_d = wdata_q[NUM_EVT-1:0];
          end
        end
        default: ;
      endcase
    end

    if (do_read && s_axi_araddr == OFF_IRQ_STATUS) begin
      status_d = '0;
    end
    // Set after clear, so an event in the clearing cycle survives
    if (port_resp.fault) begin
      status_d[EVT_FAULT] = 1'b1;
    end
    if (mode != mode_q) begin
      status_d[EVT_MODE] = 1'b1;
    end

    irq_d = |(status_d & mask_d);
  end

  // Bus channel registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
    end
  end

  // Gating registers, flags and interrupt line
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_gate_q   <= GATE_RESET[N-1:0];
      sleep_gate_q <= GATE_RESET[N-1:0];
      deep_gate_q  <= GATE_RESET[N-1:0];
      acg_q        <= CONFIG_RESET[ACG_BIT];
      status_q     <= '0;
      mask_q       <= MASK_RESET[NUM_EVT-1:0];
      irq_q        <= 1'b0;
      mode_q       <= MODE_RUN;
    end else begin
      run_gate_q   <= run_gate_d;
      sleep_gate_q <= sleep_gate_d;
      deep_gate_q  <= deep_gate_d;
      acg_q        <= acg_d;
      status_q     <= status_d;
      mask_q       <= mask_d;
      irq_q        <= irq_d;
      mode_q       <= mode;
    end
  end

  gate_select #(.N(N)) u_select (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .mode       (mode),
    .auto_gate  (acg_q),
    .run_gate   (run_gate_q),
    .sleep_gate (sleep_gate_q),
    .deep_gate  (deep_gate_q),
    .clock_en   (clock_en)
  );

  port_access_check #(.N(N)) u_check (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .req      (port_req),
    .clock_en (clock_en),
    .resp     (port_resp)
  );

  assign port_clock_en = clock_en;
  assign irq           = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
endmodule : sleep_port_clock_gating

// ==== tb/sleep_gate_monitor.sv ====
// Port-level checker for the sleep port clock gating block
`timescale 1ns/100ps
module sleep_gate_monitor import port_gate_pkg::*; #(
  parameter int N = NUM_PORTS
) (
  input wire logic         core_clk,
  input wire logic         rst_n,
  input wire port_req_t    port_req,
  input wire port_resp_t   port_resp,
  input wire logic [N-1:0] port_clock_en,
  input wire logic [11:0]  s_axi_araddr,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready
);
  logic gate_rd_d;
  logic gate_rd_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Remembers whether the read in flight targets a gate register
  always_comb begin
    gate_rd_d = gate_rd_q;
    if (s_axi_arvalid && s_axi_arready) begin
      gate_rd_d = s_axi_araddr inside {OFF_RUN_GATE, OFF_SLEEP_GATE, OFF_DEEP_GATE};
    end
  end
  always_ff @(posedge core_clk) begin
    gate_rd_q <= rst_n ? gate_rd_d : 1'b0;
  end
  a_fault_on_gated: assert property (
    port_req.valid && !port_clock_en[port_req.port] |=> port_resp == 2'h2)
    else $error("Gated port access not faulted");
  a_ok_on_clocked: assert property (
    port_req.valid && port_clock_en[port_req.port] |=> port_resp == 2'h1)
    else $error("Clocked port access not answered");
  a_resp_when_idle: assert property (
    !port_req.valid |=> port_resp == 2'h0) else $error("Port answer without request");
  a_gate_high_zero: assert property (
    s_axi_rvalid && gate_rd_q |-> s_axi_rdata[31:8] == 24'h0)
    else $error("Gate register upper bits not zero");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> port_clock_en == '0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("Outputs not quiet after reset");
  a_bresp_held: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped early");
  a_rdata_held: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("Read data dropped early");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write response late");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("Read response late");
  c_fault: cover property (port_resp.fault);
  c_ok: cover property (port_resp.ok);
  c_gate_read: cover property (gate_rd_q && s_axi_rvalid);
endmodule : sleep_gate_monitor

// ==== tb/tb_top.sv ====
// Self-checking bench for the sleep port clock gating block
`timescale 1ns/100ps
module tb_top import port_gate_pkg::*;;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  power_mode_t mode = MODE_RUN;
  port_req_t   port_req = '0;
  port_resp_t  port_resp;
  logic [7:0]  port_clock_en, run_m = '0, slp_m = '0, dp_m = '0;
  logic [1:0]  msk_m = '0, sts_m = '0, s_axi_bresp, s_axi_rresp;
  logic [31:0] cfg_m = '0, s_axi_wdata = '0, s_axi_rdata;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        irq, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  int          mismatches = 0, n_tests = 0;
  logic [11:0] regs [6] = '{OFF_RUN_GATE, OFF_SLEEP_GATE, OFF_DEEP_GATE,
                            OFF_RUN_CONFIG, OFF_IRQ_MASK, OFF_IRQ_STATUS};

  sleep_port_clock_gating sleep_port_clock_gating_i (
    .core_clk, .rst_n, .mode, .port_req, .port_resp, .port_clock_en, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );

  always #2.5 core_clk = ~core_clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  function automatic logic [31:0] exp_rd(input logic [11:0] a);
    case (a)
      OFF_RUN_GATE:   return {24'h0, run_m};
      OFF_SLEEP_GATE: return {24'h0, slp_m};
      OFF_DEEP_GATE:  return {24'h0, dp_m};
      OFF_RUN_CONFIG: return cfg_m;
      OFF_IRQ_MASK:   return {30'h0, msk_m};
      OFF_IRQ_STATUS: return {30'h0, sts_m};
      default:        return 32'h0;
    endcase
  endfunction : exp_rd

  // Auto gating off means run settings everywhere
  function automatic logic [7:0] exp_en();
    if (!cfg_m[27] || mode == MODE_RUN) return run_m;
    return (mode == MODE_SLEEP) ? slp_m : dp_m;
  endfunction : exp_en

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit aw = 0;
    bit w = 0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'($urandom_range(1));
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    if (!s_axi_bready) begin
      s_axi_bready <= 1'b1;
      @(posedge core_clk);
    end
    chk(32'(s_axi_bresp), 32'((a inside {regs}) ? RESP_OKAY : RESP_DECERR));
    s_axi_bready <= 1'b0;
    case (a)
      OFF_RUN_GATE:   run_m = d[7:0];
      OFF_SLEEP_GATE: slp_m = d[7:0];
      OFF_DEEP_GATE:  dp_m = d[7:0];
      OFF_RUN_CONFIG: cfg_m = d & 32'h0800_0000;
      OFF_IRQ_MASK:   msk_m = d[1:0];
      default:        ;
    endcase
  endtask : wr

  task automatic rchk(input logic [11:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'($urandom_range(1));
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    if (!s_axi_rready) begin
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
    end
    chk(s_axi_rdata, exp_rd(a));
    chk(32'(s_axi_rresp), 32'((a inside {regs}) ? RESP_OKAY : RESP_DECERR));
    s_axi_rready <= 1'b0;
    if (a == OFF_IRQ_STATUS) sts_m = 2'h0;
  endtask : rchk

  task automatic set_mode(input power_mode_t m);
    @(posedge core_clk);
    if (m != mode) sts_m[1] = 1'b1;
    mode <= m;
    repeat (3) @(posedge core_clk);
    chk(32'(port_clock_en), 32'(exp_en()));
  endtask : set_mode

  task automatic poke(input int p);
    logic [7:0] en;
    en = exp_en();
    @(posedge core_clk);
    port_req <= '{1'b1, 3'(p)};
    @(posedge core_clk);
    port_req <= '0;
    @(negedge core_clk);
    chk(32'(port_resp), en[p] ? 32'h1 : 32'h2);
    if (!en[p]) sts_m[0] = 1'b1;
  endtask : poke

  initial begin
    void'($urandom(32'h879F));
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (regs[k]) rchk(regs[k]);
    chk(32'(port_clock_en), 32'h0);
    rchk(12'h300);
    wr(12'h300, 32'hFFFF_FFFF);
    for (int i = 0; i < 12; i++) begin
      wr(OFF_RUN_GATE, 32'($urandom_range(255)));
      wr(OFF_SLEEP_GATE, 32'($urandom_range(255)));
      wr(OFF_DEEP_GATE, 32'($urandom_range(255)));
      wr(OFF_RUN_CONFIG, 32'($urandom_range(1)) << 27);
      wr(OFF_IRQ_MASK, 32'($urandom_range(3)));
      for (int k = 0; k < 5; k++) rchk(regs[k]);
      for (int m = 0; m < 3; m++) begin
        set_mode(power_mode_t'(m));
        for (int p = 0; p < 8; p++) poke(p);
      end
      repeat (3) @(posedge core_clk);
      chk(32'(irq), 32'(|(sts_m & msk_m)));
      rchk(OFF_IRQ_STATUS);
      repeat (3) @(posedge core_clk);
      chk(32'(irq), 32'h0);
    end
    end_sim();
  end

  // Whole run needs well under this many cycles
  initial begin
    #(60000 * 5);
    mismatches++;
    end_sim();
  end
endmodule : tb_top

bind sleep_port_clock_gating sleep_gate_monitor #(.N(N)) sleep_gate_monitor_i (
  .core_clk, .rst_n, .port_req, .port_resp, .port_clock_en, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready
);
